// >>> verilog/bt_pkg.sv
// basic timer package: register map, field layout, reset values, types
// assumes a 32-bit apb slave with one aligned word per register
package bt_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [9:0] BT_IDX_MODE = 10'h0D8;  // timer_mode_control
    localparam logic [9:0] BT_IDX_COUNT = 10'h0D9; // timer_count_value
    localparam logic [9:0] BT_IDX_CTRL = 10'h0DC;  // overflow flag and enable
    localparam logic [9:0] BT_IDX_STS = 10'h0DD;   // sticky events, read clears
    localparam logic [9:0] BT_IDX_MSK = 10'h0DE;   // event mask

    // ==========================================================
    // field positions
    localparam int BT_EN_BIT = 7;      // count_enable_bit
    localparam int BT_SEL_MSB = 6;     // prescale_select top
    localparam int BT_SEL_LSB = 4;     // prescale_select bottom
    localparam int BT_FLAG_BIT = 0;    // overflow_flag
    localparam int BT_IEN_BIT = 1;     // overflow_irq_enable
    localparam int BT_EV_OVF = 0;      // status: overflow seen
    localparam int BT_EV_WAKE = 1;     // status: green-mode wake issued
    localparam int BT_EV_N = 2;

    // ==========================================================
    // widths and values
    localparam int BT_CNT_W = 8;
    localparam int BT_SEL_W = 3;
    localparam logic [7:0] BT_RST_VAL = 8'h00;
    localparam logic [7:0] BT_CNT_FULL = 8'hFF;
    localparam logic [7:0] BT_CNT_ZERO = 8'h00;
    localparam logic [7:0] BT_MODE_WMASK = 8'hF0; // low nibble reserved, reads zero
    localparam logic [7:0] BT_PRE_ONES = 8'hFF;

    // ==========================================================
    // system power modes
    typedef enum logic [1:0] {
        BT_PM_NORMAL = 2'b00,
        BT_PM_SLOW = 2'b01,
        BT_PM_GREEN = 2'b11
    } bt_pmode_e;

    // apb slave handshake, idle goes straight to resp (two bits flip), prep unused
    typedef enum logic [1:0] {
        BT_AS_IDLE = 2'b00,
        BT_AS_PREP = 2'b01,
        BT_AS_RESP = 2'b11
    } bt_apb_e;

    // mode/control register layout
    typedef struct packed {
        logic en;
        logic [BT_SEL_W-1:0] sel;
        logic [3:0] rsvd;
    } bt_mode_s;

    // answer of the slave to one access
    typedef struct packed {
        logic [31:0] rdata;
        logic err;
    } bt_resp_s;

endpackage : bt_pkg

// >>> verilog/bt_prescaler.sv
// basic timer prescaler: divides the instruction-clock enable by 2..256
// assumes fcpu_en_i is a one-cycle pulse per instruction cycle
`timescale 1ns/1ns
module bt_prescaler
    import bt_pkg::*;
#(
    parameter int PRE_W = 8
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // control
    input wire logic fcpu_en_i,
    input wire logic run_i,
    input wire logic [BT_SEL_W-1:0] sel_i,
    // timer clock enable
    output logic tick_o
);

    logic [PRE_W-1:0] pre_q;
    logic [PRE_W-1:0] mask;

    // ==========================================================
    // select mask: 000 needs all bits set, 111 only bit 0
    always_comb begin
        mask = BT_PRE_ONES[PRE_W-1:0] >> sel_i;
    end

    // free count of instruction cycles, cleared while stopped
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_q <= '0;
        end else if (!run_i) begin
            pre_q <= '0;
        end else if (fcpu_en_i) begin
            pre_q <= pre_q + 1'b1; // R10
        end
    end

    // one tick each 2^(8-sel) instruction cycles
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= run_i && fcpu_en_i && ((pre_q & mask) == mask); // R11
        end
    end

    tick_src_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R10
        tick_o |-> $past(fcpu_en_i) && $past(run_i))
        else $error("timer tick without instruction cycle");

endmodule : bt_prescaler

// >>> verilog/bt_basic_timer.sv
// basic 8-bit up timer with prescaler, overflow flag, irq and green wake
// assumes an apb master on ref_clk_i and fcpu_en_i once per instruction
//
// How it works
// R1: counts only while enable bit set
// R2: 8-bit counter steps by one per tick
// R3: overflow only on wrap from FF to 00
// R4: overflow sets flag, only software clears
// R5: no reload; continues from zero after wrap
// R6: enabled overflow flag raises interrupt request
// R7: service routine must clear overflow flag
// R8: counts in normal, slow and green modes
// R9: green-mode overflow sets flag and wakes system
// R10: tick comes only from divided instruction clock
// R11: select 000..111 divides by 256..2
// R12: count readable and writable, write replaces count
// R13: software configures before setting enable bit
// R14: software loads count before enable, reloads after
// R15: start count is 256 minus interval times rate
// R16: overflow beats same-cycle flag clear
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
module bt_basic_timer
    import bt_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // system side
    input wire logic fcpu_en_i,
    input wire logic [1:0] power_mode_i,
    // events
    output logic irq_o,
    output logic wake_o
);

    // ==========================================================
    // state
    bt_mode_s mode_q;
    logic [BT_CNT_W-1:0] count_q;
    logic flag_q;
    logic ien_q;
    logic [BT_EV_N-1:0] sts_q;
    logic [BT_EV_N-1:0] msk_q;
    bt_apb_e as_q;
    bt_resp_s resp_d;
    bt_pmode_e pmode;

    logic tick;
    logic ovf;
    logic [9:0] idx;
    logic commit;
    logic wr_mode;
    logic wr_count;
    logic wr_ctrl;
    logic wr_msk;
    logic rd_sts;
    logic flag_clr;
    logic [BT_EV_N-1:0] ev;

    // ==========================================================
    // access decode
    assign idx = paddr[11:2];
    assign pmode = bt_pmode_e'(power_mode_i);
    // write and read-clear take effect on the edge pready is seen high
    assign commit = psel && penable && pready;
    assign wr_mode = commit && pwrite && (idx == BT_IDX_MODE);
    assign wr_count = commit && pwrite && (idx == BT_IDX_COUNT);
    assign wr_ctrl = commit && pwrite && (idx == BT_IDX_CTRL);
    assign wr_msk = commit && pwrite && (idx == BT_IDX_MSK);
    assign rd_sts = commit && !pwrite && (idx == BT_IDX_STS);
    // writing zero to the flag bit clears it, writing one is ignored
    assign flag_clr = wr_ctrl && !pwdata[BT_FLAG_BIT];

    // ==========================================================
    // prescaler from the instruction clock
    bt_prescaler #(
        .PRE_W(BT_CNT_W)
    ) u_pre (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .fcpu_en_i(fcpu_en_i), // R10
        .run_i(mode_q.en),
        .sel_i(mode_q.sel), // R11
        .tick_o(tick)
    );

    // wrap from full scale only, in every power mode
    assign ovf = tick && mode_q.en && (count_q == BT_CNT_FULL); // R3 R8

    // ==========================================================
    // mode register: enable and prescale select
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q <= bt_mode_s'(BT_RST_VAL);
        end else if (wr_mode) begin
            mode_q <= bt_mode_s'(pwdata[7:0] & BT_MODE_WMASK);
        end
    end

    // counter: software write wins, otherwise step on tick
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_q <= BT_RST_VAL;
        end else if (wr_count) begin
            count_q <= pwdata[BT_CNT_W-1:0]; // R12
        end else if (tick && mode_q.en) begin // R1 R8
            count_q <= count_q + 1'b1; // R2 R5
        end
    end

    count_no_tick_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R2
        !tick && !wr_count |=> count_q == $past(count_q))
        else $error("counter moved without a tick");

    // overflow flag: set beats clear
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
        end else if (ovf) begin
            flag_q <= 1'b1; // R4 R16
        end else if (flag_clr) begin
            flag_q <= 1'b0; // R7
        end
    end

    ovf_sets_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R4
        ovf |=> flag_q)
        else $error("overflow did not set the flag");

    // overflow interrupt enable
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ien_q <= 1'b0;
        end else if (wr_ctrl) begin
            ien_q <= pwdata[BT_IEN_BIT];
        end
    end

    // ==========================================================
    // sticky events and their mask
    assign ev[BT_EV_OVF] = ovf;
    assign ev[BT_EV_WAKE] = ovf && (pmode == BT_PM_GREEN);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sts_q <= '0;
        end else if (rd_sts) begin
            // only bits already returned are cleared, new events stay
            sts_q <= (sts_q & ~prdata[BT_EV_N-1:0]) | ev;
        end else begin
            sts_q <= sts_q | ev;
        end
    end

    sts_sticky_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !rd_sts |=> (sts_q & $past(sts_q)) == $past(sts_q))
        else $error("status bit dropped without a read");

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            msk_q <= '0;
        end else if (wr_msk) begin
            msk_q <= pwdata[BT_EV_N-1:0];
        end
    end

    // ==========================================================
    // interrupt level and green-mode wake pulse
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= (flag_q && ien_q) || (|(sts_q & msk_q)); // R6
        end
    end

    irq_masked_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R6
        |(sts_q & msk_q) |=> irq_o)
        else $error("unmasked status raised no interrupt");

    irq_quiet_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R6
        !flag_q && !(|sts_q) |=> !irq_o)
        else $error("interrupt with no cause");

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= ovf && (pmode == BT_PM_GREEN); // R9
        end
    end

    green_wake_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R9
        ovf && (pmode == BT_PM_GREEN) |=> wake_o)
        else $error("green-mode overflow gave no wake");

    wake_single_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R9
        wake_o |=> !wake_o)
        else $error("wake pulse longer than one cycle");

    // ==========================================================
    // apb read mux and unmapped answer
    always_comb begin
        resp_d = '0;
        case (idx)
            BT_IDX_MODE: resp_d.rdata[7:0] = mode_q;
            BT_IDX_COUNT: resp_d.rdata[BT_CNT_W-1:0] = count_q;
            BT_IDX_CTRL: begin
                resp_d.rdata[BT_FLAG_BIT] = flag_q;
                resp_d.rdata[BT_IEN_BIT] = ien_q;
            end
            BT_IDX_STS: resp_d.rdata[BT_EV_N-1:0] = sts_q;
            BT_IDX_MSK: resp_d.rdata[BT_EV_N-1:0] = msk_q;
            default: resp_d.err = 1'b1;
        endcase
    end

    // one wait state: answer built, then pready for one cycle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            as_q <= BT_AS_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            case (as_q)
                BT_AS_IDLE: begin
                    if (psel && penable) begin
                        as_q <= BT_AS_RESP;
                        pready <= 1'b1;
                        pslverr <= resp_d.err;
                        prdata <= pwrite ? 32'h0000_0000 : resp_d.rdata;
                    end
                end
                BT_AS_RESP: begin
                    as_q <= BT_AS_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
                default: begin
                    as_q <= BT_AS_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    ready_pulse_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        pready |=> !pready)
        else $error("ready held longer than one cycle");

    ready_wait_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        psel && penable && !pready |=> pready)
        else $error("access phase not answered next cycle");

    err_with_ready_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        pslverr |-> pready)
        else $error("error response without ready");

    // ==========================================================
    // checks
    hold_when_off_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R1
        !mode_q.en && !wr_count |=> count_q == $past(count_q))
        else $error("counter moved while disabled");

    count_step_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R2
        tick && mode_q.en && !wr_count |=> count_q == $past(count_q) + 8'h01)
        else $error("counter did not step by one");

    ovf_only_wrap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R3
        $rose(flag_q) |-> $past(count_q) == BT_CNT_FULL && $past(tick))
        else $error("overflow away from full scale");

    flag_set_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R16
        ovf ##0 flag_clr |=> flag_q)
        else $error("overflow lost to same-cycle clear");

    flag_sticky_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R4
        flag_q && !flag_clr |=> flag_q)
        else $error("flag dropped without software clear");

    wrap_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R5
        ovf && !wr_count |=> count_q == BT_CNT_ZERO)
        else $error("counter did not continue from zero");

    irq_follows_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R6
        ovf && ien_q && !wr_ctrl |=> ##1 irq_o)
        else $error("enabled overflow raised no interrupt");

    wake_green_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R9
        wake_o |-> $past(ovf) && ($past(power_mode_i) == BT_PM_GREEN) && flag_q)
        else $error("wake without green-mode overflow");

    count_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R12
        wr_count |=> count_q == $past(pwdata[7:0]))
        else $error("count write not taken");

endmodule : bt_basic_timer

// >>> testbench/test_bt_basic_timer.sv
// self-checking bench for the basic 8-bit up timer
// assumes bt_basic_timer with a 12-bit apb address and the bt_pkg register map
`timescale 1ns/1ns
module test_bt_basic_timer
    import bt_pkg::*;
;
    // ==========================================================
    // design inputs and outputs
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic fcpu_en_i = 1'b0;
    logic [1:0] power_mode_i = 2'b00;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq_o;
    logic wake_o;

    // ==========================================================
    // bench state
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;
    int wake_n = 0;
    int k;
    int dv;
    int rem;
    int wk0;
    logic [31:0] seed = 32'h87807759;
    logic [31:0] rd;
    logic err;
    logic [7:0] start;
    logic [2:0] sel;
    logic ien;
    logic ovf;
    logic grn;
    logic [1:0] msk;

    bt_basic_timer #(.ADDR_W(12)) u_bt_basic_timer (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .fcpu_en_i(fcpu_en_i),
        .power_mode_i(power_mode_i),
        .irq_o(irq_o),
        .wake_o(wake_o)
    );

    // ==========================================================
    // clock, hang guard and wake pulse counter
    initial begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (wake_o === 1'b1) wake_n <= wake_n + 1;
        if (cyc == 90000) begin
            num_errors++;
            final_report();
        end
    end

    // ==========================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs

    task automatic final_report();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    task automatic cmp(input logic [32:0] got, input logic [32:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : cmp

    // one apb transfer: setup, access, hold until pready at an edge
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) cmp(1'b0, 1'b1, "apb no ready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr_reg(input logic [9:0] idx, input logic [7:0] d);
        apb(1'b1, idx, {24'h0, d});
    endtask : wr_reg

    task automatic rd_chk(input logic [9:0] idx, input logic [7:0] e, input string msg);
        apb(1'b0, idx, 32'h0);
        cmp({err, rd}, {25'h0, e}, msg);
    endtask : rd_chk

    // instruction-cycle pulses with a gap, then let the last tick land
    task automatic pulse(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk_i);
            fcpu_en_i <= 1'b1;
            @(posedge ref_clk_i);
            fcpu_en_i <= 1'b0;
        end
        repeat (4) @(posedge ref_clk_i);
    endtask : pulse

    // ==========================================================
    // main sequence
    initial begin
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        // reset values and map
        rd_chk(BT_IDX_MODE, 8'h00, "mode reset");
        rd_chk(BT_IDX_COUNT, 8'h00, "count reset");
        rd_chk(BT_IDX_CTRL, 8'h00, "ctrl reset");
        rd_chk(BT_IDX_STS, 8'h00, "status reset");
        rd_chk(BT_IDX_MSK, 8'h00, "mask reset");
        apb(1'b0, 10'h000, 32'h0);
        cmp({err, rd}, {1'b1, 32'h0}, "unmapped read");
        // reserved nibble, flag not settable by a write
        wr_reg(BT_IDX_MODE, 8'hFF);
        rd_chk(BT_IDX_MODE, 8'hF0, "mode readback");
        wr_reg(BT_IDX_MODE, 8'h00);
        wr_reg(BT_IDX_CTRL, 8'h03);
        rd_chk(BT_IDX_CTRL, 8'h02, "ctrl readback");
        // no counting while disabled
        wr_reg(BT_IDX_CTRL, 8'h00);
        wr_reg(BT_IDX_COUNT, 8'h5A);
        wr_reg(BT_IDX_MODE, 8'h70);
        pulse(8);
        rd_chk(BT_IDX_COUNT, 8'h5A, "held count");
        // green-mode overflow on the very edge at which software clears the flag
        power_mode_i <= 2'b11;
        wr_reg(BT_IDX_COUNT, 8'hFF);
        wk0 = wake_n;
        wr_reg(BT_IDX_MODE, 8'hF0);
        fork
            wr_reg(BT_IDX_CTRL, 8'h00);
            begin
                @(posedge ref_clk_i);
                fcpu_en_i <= 1'b1;
            end
        join
        fcpu_en_i <= 1'b0;
        wr_reg(BT_IDX_MODE, 8'h00);
        rd_chk(BT_IDX_CTRL, 8'h01, "flag beats clear");
        cmp(33'(wake_n - wk0), 33'h1, "green wake");
        rd_chk(BT_IDX_STS, 8'h03, "green events");
        // every prescale code, random start, enables and remainder, power mode from the loop index
        for (int it = 0; it < 16; it++) begin
            seed = xs(seed);
            sel = it[2:0];
            dv = 256 >> sel;
            k = 1 + seed[1:0];
            rem = int'(seed[15:8]) % dv;
            // near-full start is FF minus a random 0..7
            start = it[3] ? 8'hFF - {5'h0, seed[18:16]} : seed[31:24];
            ien = seed[19];
            msk = seed[21:20];
            grn = ((it[1:0] ^ it[3:2]) == 2'b11);
            ovf = (int'(start) + k) > 255;
            power_mode_i <= it[1:0] ^ it[3:2];
            wr_reg(BT_IDX_MSK, {6'h0, msk});
            wr_reg(BT_IDX_CTRL, {6'h0, ien, 1'b0});
            wr_reg(BT_IDX_COUNT, start);
            wr_reg(BT_IDX_MODE, {1'b0, sel, 4'h0});
            wr_reg(BT_IDX_MODE, {1'b1, sel, 4'h0});
            wk0 = wake_n;
            pulse(dv * k + rem);
            wr_reg(BT_IDX_MODE, 8'h00);
            rd_chk(BT_IDX_COUNT, start + k[7:0], "count steps");
            rd_chk(BT_IDX_CTRL, {6'h0, ien, ovf}, "overflow flag");
            cmp(irq_o, ovf & (ien | msk[0] | (grn & msk[1])), "irq level");
            cmp(33'(wake_n - wk0), ovf & grn, "wake pulses");
            wr_reg(BT_IDX_CTRL, 8'h00);
            rd_chk(BT_IDX_STS, {6'h0, ovf & grn, ovf}, "status events");
            rd_chk(BT_IDX_STS, 8'h00, "status cleared");
            repeat (3) @(posedge ref_clk_i);
            cmp(irq_o, 1'b0, "irq released");
        end
        final_report();
    end

endmodule : test_bt_basic_timer
